// *** pwm_pair_pkg.sv ***
// Operation
// RULE1 - reset-synchronized mode: three pairs, common edge
// RULE2 - sync mode: pins become PWM, counter up-only
// RULE3 - each phase output drives its complement pin
// RULE4 - sync mode: main starts zero, partner detached
// RULE5 - main equals period: clear, count from zero
// RULE6 - three edge registers set pair transitions
// RULE7 - sync mode: toggle on match and clear
// RULE8 - complementary mode: non-overlapping pairs, up/down counters
// RULE9 - software presets partner zero, main margin
// RULE10 - software sets period as limit minus one
// RULE11 - down at period match, up at underflow
// RULE12 - match order main, partner, partner, main
// RULE13 - edge above period never matches
// RULE14 - counters overshoot and undershoot at turns
// RULE15 - match flag set only while counting up
// RULE16 - overflow flag only on partner underflow; normal and sync modes also set it at partner count FFFF
// RULE17 - comp buffering: copy at period-up, underflow
// RULE18 - software avoids low edges before first match
// RULE19 - software changes edges through buffer registers
// RULE20 - sync buffering: copy at period match
// RULE21 - level select bits invert pair outputs
// RULE22 - capture input clears output enables
// RULE23 - mode bits select normal, sync, complementary
// RULE24 - pair halves switch on different counters
`timescale 1ns/1ps

package pwm_pair_pkg;
   localparam int NPAIR = 3;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_SYNC = 2'b01,
      MODE_COMP = 2'b10
   } mode_e;
   // register indices on the plain register port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_OE = 4'h1;
   localparam logic [3:0] OFS_STAT = 4'h2;
   localparam logic [3:0] OFS_MAIN = 4'h3;
   localparam logic [3:0] OFS_PART = 4'h4;
   localparam logic [3:0] OFS_PERIOD = 4'h5;
   localparam logic [3:0] OFS_EDGE0 = 4'h6;
   localparam logic [3:0] OFS_BUF0 = 4'h9;
   // control and status register fields
   localparam int CB_MODE = 0;
   localparam int CB_RUN = 2;
   localparam int CB_BUFEN = 3;
   localparam int CB_EXT_TRIGGER_DISABLE_N_N = 4;
   localparam int CB_LEVEL_SEL_CH3 = 5;
   localparam int CB_LEVEL_SEL_CH4 = 6;
   localparam int SB_MATCH = 0;
   localparam int SB_OVF = 1;
   localparam logic [15:0] CTRL_RST = 16'h0070;
   localparam logic [5:0] OE_RST = 6'h00;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [15:0] ALL16 = 16'hFFFF;
endpackage

// one output pair: edge state for both combined modes
module pwm_phase_cell
   import pwm_pair_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire mode_e mode,
   input wire logic hit_main,
   input wire logic hit_partner,
   input wire logic up,
   input wire logic toggle_all,
   output logic pos,
   output logic neg
);
   typedef struct packed {
      logic s;
      logic p;
      logic n;
   } cell_s;
   cell_s q;
   cell_s next_q;

   // sync mode toggles one bit; comp mode keeps two halves apart
   always_comb begin
      next_q = q;
      unique case (mode)
         MODE_SYNC: begin
            if (hit_main ^ toggle_all) begin
               next_q.s = ~q.s; // [RULE7]
            end
         end
         MODE_COMP: begin
            // negative half follows main, positive half follows partner
            if (hit_main) begin
               next_q.n = ~up; // [RULE24] [RULE12]
            end
            if (hit_partner) begin
               next_q.p = up; // [RULE24]
            end
         end
         default: begin
            next_q = '{s: 1'b0, p: 1'b0, n: 1'b1};
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '{s: 1'b0, p: 1'b0, n: 1'b1};
      end else begin
         q <= next_q;
      end
   end

   // complement pin is the inverse in sync mode
   assign pos = (mode == MODE_SYNC) ? q.s : q.p; // [RULE3]
   assign neg = (mode == MODE_SYNC) ? ~q.s : q.n; // [RULE3]
endmodule

// *** pwm_pair_unit.sv ***
`timescale 1ns/1ps

module pwm_pair_unit
   import pwm_pair_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic CAPTURE_IN,
   output logic PHASE1_OUT,
   output logic PHASE1_OUT_N,
   output logic PHASE2_OUT,
   output logic PHASE2_OUT_N,
   output logic PHASE3_OUT,
   output logic PHASE3_OUT_N
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [5:0] oe;
      logic match_a_flag;
      logic overflow_flag;
      logic [15:0] main_counter;
      logic [15:0] partner_counter;
      logic [15:0] period_limit_reg;
      logic [NPAIR-1:0][15:0] phase_edge_reg;
      logic [NPAIR-1:0][15:0] phase_buf_reg;
      logic up;
      logic [1:0] cap_sync;
      logic cap_prev;
      logic [15:0] rdata;
      logic [5:0] pins;
   } state_s;

   state_s q;
   state_s next_q;

   mode_e mode;
   logic run;
   logic sync_m;
   logic comp_m;
   logic per_hit;
   logic underflow;
   logic buf_copy;
   logic cap_rise;
   logic [NPAIR-1:0] hit_main;
   logic [NPAIR-1:0] hit_partner;
   logic [NPAIR-1:0] pos_raw;
   logic [NPAIR-1:0] neg_raw;

   // register select, shared by the write and read paths
   function automatic logic reg_sel(input logic [3:0] a,
                                    input logic [3:0] idx);
      reg_sel = (a == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // mode decode and event detection

   // code 2'b11 is reserved and behaves as normal mode
   always_comb begin
      unique case (q.ctrl[CB_MODE +: 2])
         MODE_SYNC: mode = MODE_SYNC;
         MODE_COMP: mode = MODE_COMP;
         default: mode = MODE_NORMAL;
      endcase
   end

   assign run = q.ctrl[CB_RUN];
   assign sync_m = (mode == MODE_SYNC); // [RULE23]
   assign comp_m = (mode == MODE_COMP); // [RULE23]

   // period match: in comp mode only on the way up, so the overshoot
   // back through the period value on the way down stays silent
   assign per_hit = run && (q.main_counter == q.period_limit_reg)
                    && (sync_m || (comp_m && q.up)); // [RULE11]
   assign underflow = run && comp_m && !q.up
                      && (q.partner_counter == ZERO16); // [RULE11]
   assign buf_copy = q.ctrl[CB_BUFEN]
                     && (per_hit || underflow); // [RULE17] [RULE20]
   // edge detect sits behind the two-stage synchroniser
   assign cap_rise = q.cap_sync[1] && !q.cap_prev;

   // compare hits per pair; in comp mode values above the period never match
   generate
      for (genvar k = 0; k < NPAIR; k++) begin : g_hit
         logic in_range;
         assign in_range = !comp_m
                           || (q.phase_edge_reg[k] <= q.period_limit_reg);
         assign hit_main[k] = run && (sync_m || comp_m) && in_range
                   && (q.main_counter == q.phase_edge_reg[k]); // [RULE6] [RULE13]
         assign hit_partner[k] = run && comp_m && in_range
                   && (q.partner_counter == q.phase_edge_reg[k]); // [RULE4] [RULE13]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // output pair cells

   generate
      for (genvar k = 0; k < NPAIR; k++) begin : g_cell
         pwm_phase_cell u_cell (
            .clk(MCLK),
            .srst(SRST),
            .mode(mode),
            .hit_main(hit_main[k]),
            .hit_partner(hit_partner[k]),
            .up(q.up),
            .toggle_all(per_hit && sync_m), // [RULE1] [RULE7]
            .pos(pos_raw[k]),
            .neg(neg_raw[k])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [NPAIR-1:0] ols;
      logic [5:0] lvl;
      ols = '0;
      lvl = '0;
      next_q = q;
      next_q.cap_sync = {q.cap_sync[0], CAPTURE_IN};
      next_q.cap_prev = q.cap_sync[1];

      // counters: normal and sync count up, comp counts both ways
      if (run) begin
         unique case (mode)
            MODE_SYNC: begin
               next_q.main_counter = per_hit ? ZERO16
                  : q.main_counter + ONE16; // [RULE2] [RULE5]
               next_q.partner_counter = q.partner_counter + ONE16; // [RULE4]
               next_q.up = 1'b1;
            end
            MODE_COMP: begin
               // the count step is taken at the turn as well, which
               // gives the overshoot and undershoot of one count
               if (q.up) begin
                  next_q.main_counter = q.main_counter + ONE16;
                  next_q.partner_counter = q.partner_counter + ONE16;
                  if (per_hit) begin
                     next_q.up = 1'b0; // [RULE11] [RULE14] [RULE8]
                  end
               end else begin
                  next_q.main_counter = q.main_counter - ONE16;
                  next_q.partner_counter = q.partner_counter - ONE16;
                  if (underflow) begin
                     next_q.up = 1'b1; // [RULE11] [RULE14]
                  end
               end
            end
            default: begin
               next_q.main_counter = q.main_counter + ONE16;
               next_q.partner_counter = q.partner_counter + ONE16;
            end
         endcase
      end

      // buffer transfer at the direction turns or the period clear
      if (buf_copy) begin
         next_q.phase_edge_reg = q.phase_buf_reg; // [RULE17] [RULE20]
      end

      // software writes; status bits are write-one-to-clear
      if (WR) begin
         if (reg_sel(ADDR, OFS_CTRL)) begin
            next_q.ctrl = WDATA;
            next_q.up = 1'b1;
            // entering sync mode starts the period from zero
            if (WDATA[CB_MODE +: 2] == MODE_SYNC && !sync_m) begin
               next_q.main_counter = ZERO16; // [RULE4]
            end
         end
         if (reg_sel(ADDR, OFS_OE)) begin
            next_q.oe = WDATA[5:0];
         end
         if (reg_sel(ADDR, OFS_STAT)) begin
            if (WDATA[SB_MATCH]) begin
               next_q.match_a_flag = 1'b0;
            end
            if (WDATA[SB_OVF]) begin
               next_q.overflow_flag = 1'b0;
            end
         end
         if (reg_sel(ADDR, OFS_MAIN)) begin
            next_q.main_counter = WDATA;
         end
         if (reg_sel(ADDR, OFS_PART)) begin
            next_q.partner_counter = WDATA;
         end
         if (reg_sel(ADDR, OFS_PERIOD)) begin
            next_q.period_limit_reg = WDATA;
         end
         for (int k = 0; k < NPAIR; k++) begin
            if (reg_sel(ADDR, OFS_EDGE0 + 4'(k))) begin
               next_q.phase_edge_reg[k] = WDATA;
            end
            if (reg_sel(ADDR, OFS_BUF0 + 4'(k))) begin
               next_q.phase_buf_reg[k] = WDATA;
            end
         end
      end

      // flag sets come after the clear so a same-cycle event wins
      if (per_hit) begin
         next_q.match_a_flag = 1'b1; // [RULE15]
      end
      if ((comp_m && underflow) || (!comp_m && run
          && q.partner_counter == ALL16)) begin
         next_q.overflow_flag = 1'b1; // [RULE16]
      end

      // external trip overrides any enable written this cycle
      if (cap_rise && !q.ctrl[CB_EXT_TRIGGER_DISABLE_N_N] && (sync_m || comp_m)) begin
         next_q.oe = '0; // [RULE22]
      end

      // read data stands one cycle after the strobe
      next_q.rdata = ZERO16;
      if (RD) begin
         unique case (1'b1)
            reg_sel(ADDR, OFS_CTRL): next_q.rdata = q.ctrl;
            reg_sel(ADDR, OFS_OE): next_q.rdata = {10'h000, q.oe};
            reg_sel(ADDR, OFS_STAT):
               next_q.rdata = {12'h000, 1'b0, q.up,
                               q.overflow_flag, q.match_a_flag};
            reg_sel(ADDR, OFS_MAIN): next_q.rdata = q.main_counter;
            reg_sel(ADDR, OFS_PART): next_q.rdata = q.partner_counter;
            reg_sel(ADDR, OFS_PERIOD): next_q.rdata = q.period_limit_reg;
            reg_sel(ADDR, OFS_EDGE0): next_q.rdata = q.phase_edge_reg[0];
            reg_sel(ADDR, 4'(OFS_EDGE0 + 4'h1)):
               next_q.rdata = q.phase_edge_reg[1];
            reg_sel(ADDR, 4'(OFS_EDGE0 + 4'h2)):
               next_q.rdata = q.phase_edge_reg[2];
            reg_sel(ADDR, OFS_BUF0): next_q.rdata = q.phase_buf_reg[0];
            reg_sel(ADDR, 4'(OFS_BUF0 + 4'h1)):
               next_q.rdata = q.phase_buf_reg[1];
            reg_sel(ADDR, 4'(OFS_BUF0 + 4'h2)):
               next_q.rdata = q.phase_buf_reg[2];
            default: next_q.rdata = ZERO16; // unmapped reads as zero
         endcase
      end

      // pin levels: a cleared level select bit inverts, a cleared enable or normal
      // mode parks the pin low
      ols = {q.ctrl[CB_LEVEL_SEL_CH4], q.ctrl[CB_LEVEL_SEL_CH4], q.ctrl[CB_LEVEL_SEL_CH3]};
      for (int k = 0; k < NPAIR; k++) begin
         lvl[2*k] = pos_raw[k] ~^ ols[k]; // [RULE21]
         lvl[2*k+1] = neg_raw[k] ~^ ols[k]; // [RULE21] [RULE3]
      end
      next_q.pins = (sync_m || comp_m) ? (lvl & q.oe) : 6'h00; // [RULE2]
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.oe <= OE_RST;
         q.up <= 1'b1;
         q.period_limit_reg <= ALL16;
      end else begin
         q <= next_q;
      end
   end

   assign RDATA = q.rdata;
   assign PHASE1_OUT = q.pins[0];
   assign PHASE1_OUT_N = q.pins[1];
   assign PHASE2_OUT = q.pins[2];
   assign PHASE2_OUT_N = q.pins[3];
   assign PHASE3_OUT = q.pins[4];
   assign PHASE3_OUT_N = q.pins[5];

   ////////////////////////////////////////////////////////////////////////
   // assertions

   AST_SYNC_CLEAR: assert property (@(posedge MCLK) disable iff (SRST) // [RULE5]
      sync_m && per_hit && !WR |=> q.main_counter == ZERO16)
      else $error("main counter not cleared at period match");

   AST_SYNC_UP: assert property (@(posedge MCLK) disable iff (SRST) // [RULE2]
      sync_m && run && !per_hit && !WR
      |=> q.main_counter == $past(q.main_counter) + ONE16)
      else $error("main counter failed to count up in sync mode");

   AST_COMP_TURN: assert property (@(posedge MCLK) disable iff (SRST) // [RULE11]
      comp_m && per_hit && !WR |=> !q.up ##1 (q.main_counter
         == $past(q.main_counter) - ONE16 || $past(WR)))
      else $error("counters did not turn down at period match");

   AST_UNDERFLOW: assert property (@(posedge MCLK) disable iff (SRST) // [RULE16]
      underflow && !WR |=> q.up && q.overflow_flag
         && q.partner_counter == ALL16)
      else $error("underflow did not turn counters or set flag");

   AST_MATCH_UP: assert property (@(posedge MCLK) disable iff (SRST) // [RULE15]
      comp_m && !q.match_a_flag ##1 q.match_a_flag |-> $past(q.up))
      else $error("match flag set while counting down");

   AST_NO_OVF_UP: assert property (@(posedge MCLK) disable iff (SRST) // [RULE16]
      comp_m && q.up && !q.overflow_flag |=> !q.overflow_flag)
      else $error("overflow flag set on upward count");

   AST_PAIR_COMP: assert property (@(posedge MCLK) disable iff (SRST) // [RULE3]
      $past(sync_m && q.oe[1:0] == 2'b11) |-> PHASE1_OUT != PHASE1_OUT_N)
      else $error("pair one outputs not complementary");

   AST_NEVER_MATCH: assert property (@(posedge MCLK) disable iff (SRST) // [RULE13]
      comp_m && q.phase_edge_reg[2] > q.period_limit_reg
      |-> !hit_main[2] && !hit_partner[2])
      else $error("edge above period produced a match");

   AST_BUF_COPY: assert property (@(posedge MCLK) disable iff (SRST) // [RULE17]
      buf_copy && !WR |=> q.phase_edge_reg == $past(q.phase_buf_reg))
      else $error("buffer not copied at transfer point");

   AST_TRIP: assert property (@(posedge MCLK) disable iff (SRST) // [RULE22]
      cap_rise && !q.ctrl[CB_EXT_TRIGGER_DISABLE_N_N] && (sync_m || comp_m)
      |=> q.oe == 6'h00 ##1 q.pins == 6'h00)
      else $error("capture trip did not disable outputs");

   AST_NORMAL_PINS: assert property (@(posedge MCLK) disable iff (SRST) // [RULE23]
      mode == MODE_NORMAL |=> q.pins == 6'h00)
      else $error("pins active in normal mode");

   COV_SYNC_PERIOD: cover property (@(posedge MCLK) disable iff (SRST)
      sync_m && per_hit);
   COV_COMP_CYCLE: cover property (@(posedge MCLK) disable iff (SRST)
      comp_m && per_hit ##[1:1000] underflow);
   COV_BUF: cover property (@(posedge MCLK) disable iff (SRST)
      comp_m && buf_copy);
   COV_TRIP: cover property (@(posedge MCLK) disable iff (SRST)
      cap_rise && !q.ctrl[CB_EXT_TRIGGER_DISABLE_N_N] && comp_m);
endmodule

// *** power_stage_model.sv ***
`timescale 1ns/1ps

// gate driver side: latches any cycle where both switches of a leg are on
module power_stage_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic hi1,
   input wire logic lo1,
   input wire logic hi2,
   input wire logic lo2,
   input wire logic hi3,
   input wire logic lo3,
   output logic shoot
);
   ////////////////////////////////////////////////////////////////////////
   // sticky so that a single-cycle overlap is not lost between checks
   always_ff @(posedge clk) begin
      if (srst) begin
         shoot <= 1'b0;
      end else if ((hi1 & lo1) | (hi2 & lo2) | (hi3 & lo3)) begin
         shoot <= 1'b1;
      end
   end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps

module tb;
   import pwm_pair_pkg::*;
   logic MCLK = 1'b0;
   logic SRST = 1'b1;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic CAPTURE_IN = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0000;
   logic [15:0] RDATA;
   logic [15:0] rd_val;
   logic [15:0] v;
   logic shoot;
   wire [5:0] pins;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int hi1, tg1, tg2, tg3, tall, ncomp, h;

   pwm_pair_unit dut (
      .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .CAPTURE_IN(CAPTURE_IN),
      .PHASE1_OUT(pins[0]), .PHASE1_OUT_N(pins[1]),
      .PHASE2_OUT(pins[2]), .PHASE2_OUT_N(pins[3]),
      .PHASE3_OUT(pins[4]), .PHASE3_OUT_N(pins[5])
   );

   power_stage_model stage (
      .clk(MCLK), .srst(SRST), .hi1(pins[0]), .lo1(pins[1]),
      .hi2(pins[2]), .lo2(pins[3]), .hi3(pins[4]), .lo3(pins[5]),
      .shoot(shoot)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock and a hang guard well above the roughly 530 cycles needed
   initial begin
      forever #2 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // report and bus helpers
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 rd_val = RDATA;
   endtask

   // watches n settled cycles: high time, toggles, common edges, pairing
   task automatic win(input int n);
      logic [5:0] prev;
      logic [5:0] cur;
      hi1 = 0;
      tg1 = 0;
      tg2 = 0;
      tg3 = 0;
      tall = 0;
      ncomp = 0;
      // settle first, so the window spans exactly n clock boundaries
      #1 prev = pins;
      repeat (n) begin
         @(posedge MCLK);
         #1 cur = pins;
         if (cur[0] === 1'b1) hi1++;
         if (cur[0] !== prev[0]) tg1++;
         if (cur[2] !== prev[2]) tg2++;
         if (cur[4] !== prev[4]) tg3++;
         if ((cur ^ prev) === 6'h3F) tall++;
         if ({cur[5], cur[3], cur[1]} !== ~{cur[4], cur[2], cur[0]}) ncomp++;
         prev = cur;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd(OFS_CTRL);
      chk("ctrl", rd_val, 16'h0070);
      rd(OFS_OE);
      chk("oe", rd_val, 16'h0000);
      rd(OFS_PERIOD);
      chk("period", rd_val, 16'hFFFF);
      rd(4'hC);
      chk("unmapped", rd_val, 16'h0000);
      chk("pins idle", {10'h000, pins}, 16'h0000);
   endtask

   // period 9 gives 10-cycle frames, so 40 cycles hold four of each event
   task automatic t_sync();
      wr(OFS_PERIOD, 16'h0009);
      wr(OFS_EDGE0, 16'h0003);
      wr(OFS_EDGE0 + 4'h1, 16'h0005);
      wr(OFS_EDGE0 + 4'h2, 16'h0007);
      wr(OFS_OE, 16'h003F);
      wr(OFS_CTRL, 16'h0075);
      repeat (20) @(posedge MCLK);
      win(40);
      chk("pair1 toggles", 16'(tg1), 16'h0008);
      chk("pair2 toggles", 16'(tg2), 16'h0008);
      chk("pair3 toggles", 16'(tg3), 16'h0008);
      chk("common edges", 16'(tall), 16'h0004);
      chk("complement", 16'(ncomp), 16'h0000);
      h = hi1;
      rd(OFS_MAIN);
      chk("main in range", {15'h0000, rd_val <= 16'h0009}, 16'h0001);
      rd(OFS_PART);
      v = rd_val;
      rd(OFS_PART);
      chk("partner free", rd_val - v, 16'h0002);
      // pair1 polarity flips, so its high time becomes the complement
      wr(OFS_CTRL, 16'h0055);
      repeat (4) @(posedge MCLK);
      win(40);
      chk("inverted duty", 16'(hi1 + h), 16'h0028);
      // buffered edge lands at the next period clear
      wr(OFS_BUF0, 16'h0004);
      wr(OFS_CTRL, 16'h005D);
      repeat (12) @(posedge MCLK);
      rd(OFS_EDGE0);
      chk("sync buffer copy", rd_val, 16'h0004);
   endtask

   // capture pin passes a synchronizer, so allow several cycles
   task automatic t_capture();
      wr(OFS_CTRL, 16'h0065);
      @(posedge MCLK);
      CAPTURE_IN <= 1'b1;
      repeat (8) @(posedge MCLK);
      CAPTURE_IN <= 1'b0;
      rd(OFS_OE);
      chk("oe after capture", rd_val, 16'h0000);
      chk("pins off", {10'h000, pins}, 16'h0000);
   endtask

   // margin 2, period 19; pair3 edge lies above the period
   task automatic t_comp();
      wr(OFS_CTRL, 16'h0070);
      wr(OFS_PART, 16'h0000);
      wr(OFS_MAIN, 16'h0002);
      wr(OFS_PERIOD, 16'h0013);
      wr(OFS_BUF0, 16'h0006);
      wr(OFS_BUF0 + 4'h1, 16'h000A);
      wr(OFS_BUF0 + 4'h2, 16'h0019);
      wr(OFS_EDGE0, 16'h0006);
      wr(OFS_EDGE0 + 4'h1, 16'h000A);
      wr(OFS_EDGE0 + 4'h2, 16'h0019);
      wr(OFS_STAT, 16'h0003);
      wr(OFS_OE, 16'h003F);
      wr(OFS_CTRL, 16'h007E);
      repeat (20) @(posedge MCLK);
      win(200);
      chk("pair1 runs", {15'h0000, tg1 > 0}, 16'h0001);
      chk("pair2 runs", {15'h0000, tg2 > 0}, 16'h0001);
      chk("pair3 held", 16'(tg3), 16'h0000);
      chk("no overlap", {15'h0000, shoot}, 16'h0000);
      rd(OFS_STAT);
      chk("flags", {14'h0000, rd_val[1:0]}, 16'h0003);
      rd(OFS_MAIN);
      chk("main bound", {15'h0000, rd_val <= 16'h0014}, 16'h0001);
      wr(OFS_BUF0 + 4'h2, 16'h0008);
      repeat (100) @(posedge MCLK);
      rd(OFS_EDGE0 + 4'h2);
      chk("buffer copy", rd_val, 16'h0008);
      wr(OFS_CTRL, 16'h0070);
      repeat (3) @(posedge MCLK);
      chk("normal pins", {10'h000, pins}, 16'h0000);
      // reserved mode code must behave as normal mode
      wr(OFS_CTRL, 16'h0077);
      repeat (3) @(posedge MCLK);
      chk("reserved mode pins", {10'h000, pins}, 16'h0000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (4) @(posedge MCLK);
      SRST <= 1'b0;
      t_reset();
      t_sync();
      t_capture();
      t_comp();
      wrap_up();
   end
endmodule
